/* fecm_pkg.sv */
package fecm_pkg;
	// Register indices; byte address is index times four
	localparam logic [21:0] IDX_GEAR_NUM = 22'h250801;
	localparam logic [21:0] IDX_PULSE_FMT = 22'h250803;
	localparam logic [21:0] IDX_PRE_CNT = 22'h250804;
	localparam logic [21:0] IDX_EXT_SPEED = 22'h25080c;
	localparam logic [21:0] IDX_CL_SEL = 22'h250a02;
	localparam logic [21:0] IDX_EXT_DIR = 22'h250a03;
	localparam logic [21:0] IDX_FILTER = 22'h250a04;
	localparam logic [21:0] IDX_MOT_TERM = 22'h250a05;
	localparam logic [21:0] IDX_EXT_TERM = 22'h250a06;
	localparam logic [21:0] IDX_ABS_POS = 22'h250a07;
	localparam logic [21:0] IDX_EXT_VEL = 22'h250a08;
	localparam logic [21:0] IDX_TOL = 22'h250a09;
	localparam logic [21:0] IDX_ENC_CYCLE = 22'h250a10;
	localparam logic [21:0] IDX_CTRL = 22'h250a11;
	localparam logic [21:0] IDX_IRQ_STAT = 22'h250a12;
	localparam logic [21:0] IDX_IRQ_MASK = 22'h250a13;
	// Reset values
	localparam logic [15:0] RST_GEAR_NUM = 16'h03e8;
	localparam logic [1:0] RST_PULSE_FMT = 2'h1;
	localparam logic [7:0] RST_CL_SEL = 8'h00;
	localparam logic [7:0] RST_EXT_DIR = 8'h01;
	localparam logic [15:0] RST_FILTER = 16'h000a;
	localparam logic [15:0] RST_MOT_TERM = 16'h0000;
	localparam logic [15:0] RST_EXT_TERM = 16'h0000;
	// Tolerance in 1/256 units: 6/256 is 2.34 percent
	localparam logic [7:0] RST_TOL = 8'h06;
	localparam logic [31:0] RST_ENC_CYCLE = 32'h0000_0000;
	// Control bits
	localparam int CTRL_CLR_PRE = 0;
	localparam int CTRL_RESTART = 1;
	// Status bits
	localparam int ST_RATIO = 0;
	localparam int ST_DIR = 1;
	localparam int ST_INDEX = 2;
	localparam int ST_W = 3;
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int SPEED_WIN_US = 250;
	localparam int SPEED_WIN_CYC = SPEED_WIN_US * CLK_MHZ;
	localparam int MS_US = 1000;
	localparam int MS_CYC = MS_US * CLK_MHZ;
	typedef enum logic [1:0] {
		FMT_CW_CCW = 2'b00,
		FMT_PULSE_DIR = 2'b01,
		FMT_QUAD = 2'b10
	} fecm_fmt_e;
endpackage

/* fecm_cnt_if.sv */
`timescale 1ns/10ps
interface fecm_cnt_if;
	logic step;
	logic down;
	logic index;
	modport src(output step, output down, output index);
	modport dst(input step, input down, input index);
endinterface

/* fecm_decode.sv */
`timescale 1ns/10ps
module fecm_decode (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Encoder pins
	input wire logic phase_a_input_pos,
	input wire logic phase_b_input_pos,
	input wire logic index_input_pos,
	// Active format
	input wire logic [1:0] pulse_input_format,
	// Decoded counts
	fecm_cnt_if.src cnt
);
	logic [2:0] sync1, sync2, prev;
	logic next_step, next_down, next_index;
	logic step, down, index;
	logic a, b, pa, pb;

	always_comb begin
		a = sync2[0];
		b = sync2[1];
		pa = prev[0];
		pb = prev[1];
		next_step = 1'b0;
		next_down = down;
		next_index = sync2[2] & ~prev[2];
		case (pulse_input_format)
			fecm_pkg::FMT_CW_CCW: begin
				next_step = (a & ~pa) ^ (b & ~pb);
				next_down = b & ~pb;
			end
			fecm_pkg::FMT_PULSE_DIR: begin
				next_step = a & ~pa;
				next_down = b;
			end
			fecm_pkg::FMT_QUAD: begin
				// Double change is an illegal jump; dropped
				next_step = (a ^ pa) ^ (b ^ pb);
				next_down = ~(a ^ pb);
			end
			default: next_step = 1'b0;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			prev <= 3'h0;
			step <= 1'b0;
			down <= 1'b0;
			index <= 1'b0;
		end else begin
			sync1 <= {index_input_pos, phase_b_input_pos, phase_a_input_pos};
			sync2 <= sync1;
			prev <= sync2;
			step <= next_step;
			down <= next_down;
			index <= next_index;
		end
	end

	assign cnt.step = step;
	assign cnt.down = down;
	assign cnt.index = index;
endmodule

/* fecm_top.sv */
`timescale 1ns/10ps
module fecm_top #(
	parameter int SPEED_WIN_CYC = fecm_pkg::SPEED_WIN_CYC,
	parameter int MS_CYC = fecm_pkg::MS_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [23:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External encoder pins
	input wire logic phase_a_input_pos,
	input wire logic phase_b_input_pos,
	input wire logic index_input_pos,
	// Motor encoder increments, same clock
	input wire logic motor_step,
	input wire logic motor_down,
	// Status outputs
	output logic pulse_cmd_enable,
	output logic closed_loop_fault,
	output logic irq
);
	fecm_cnt_if cnt();

	logic [15:0] gear_factor_numerator, next_gear_factor_numerator;
	logic [1:0] fmt_saved, next_fmt_saved, fmt_active, next_fmt_active;
	logic [7:0] closed_loop_select, next_closed_loop_select;
	logic [7:0] ext_encoder_direction, next_ext_encoder_direction;
	logic [15:0] mismatch_filter_time, next_mismatch_filter_time;
	logic [15:0] motor_ratio_term, next_motor_ratio_term;
	logic [15:0] ext_ratio_term, next_ext_ratio_term;
	logic [7:0] ratio_tolerance, next_ratio_tolerance;
	logic [31:0] enc_cycle, next_enc_cycle;
	logic [31:0] pre_count, next_pre_count;
	logic [31:0] ext_absolute_position, next_ext_absolute_position;
	logic [31:0] motor_pos, next_motor_pos;
	logic [31:0] ext_snap, next_ext_snap, mot_snap, next_mot_snap;
	logic [15:0] ext_velocity, next_ext_velocity;
	logic [31:0] win_cnt, next_win_cnt;
	logic [31:0] idx_cnt, next_idx_cnt;
	logic idx_seen, next_idx_seen;
	logic ext_dn, next_ext_dn, ext_valid, next_ext_valid;
	logic mot_dn, next_mot_dn, mot_valid, next_mot_valid;
	logic ratio_bad, next_ratio_bad;
	logic [31:0] ms_div, next_ms_div;
	logic [15:0] ms_cnt, next_ms_cnt;
	logic [fecm_pkg::ST_W-1:0] irq_status, next_irq_status;
	logic [fecm_pkg::ST_W-1:0] irq_mask, next_irq_mask;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic next_pulse_cmd_enable, next_closed_loop_fault, next_irq;

	// Combinational helpers
	logic [21:0] idx;
	logic hit, wr, rd_ok, closed_on, step_dn, win_end, dir_bad, bad;
	logic [31:0] ext_d, mot_d, rd_val;
	logic [15:0] ext_mag, mot_mag;
	logic [31:0] prod_e, prod_m, diff;
	logic [39:0] err_scaled, band;
	logic [fecm_pkg::ST_W-1:0] set_ev, clr_ev;

	fecm_decode u_decode (
		.clock(clock),
		.sys_rst(sys_rst),
		.phase_a_input_pos(phase_a_input_pos),
		.phase_b_input_pos(phase_b_input_pos),
		.index_input_pos(index_input_pos),
		.pulse_input_format(fmt_active),
		.cnt(cnt.src)
	);

	always_comb begin
		idx = paddr[23:2];
		hit = psel & penable & pready;
		wr = hit & pwrite & (paddr[1:0] == 2'h0);
		closed_on = closed_loop_select != 8'h00;
		step_dn = cnt.down ^ (ext_encoder_direction == 8'h00);
		win_end = win_cnt == 32'(SPEED_WIN_CYC - 1);
		ext_d = ext_absolute_position - ext_snap;
		mot_d = motor_pos - mot_snap;
		ext_mag = ext_d[31] ? 16'(-ext_d) : ext_d[15:0];
		mot_mag = mot_d[31] ? 16'(-mot_d) : mot_d[15:0];
		// Scaled motions should match: ext*slave vs motor*master
		prod_e = ext_mag * ext_ratio_term;
		prod_m = mot_mag * motor_ratio_term;
		diff = (prod_e > prod_m) ? prod_e - prod_m : prod_m - prod_e;
		err_scaled = {diff, 8'h00};
		band = ratio_tolerance * {8'h00, prod_m};
		dir_bad = closed_on & ext_valid & mot_valid & (ext_dn != mot_dn);
		bad = dir_bad | ratio_bad;

		next_gear_factor_numerator = gear_factor_numerator;
		next_fmt_saved = fmt_saved;
		next_fmt_active = fmt_active;
		next_closed_loop_select = closed_loop_select;
		next_ext_encoder_direction = ext_encoder_direction;
		next_mismatch_filter_time = mismatch_filter_time;
		next_motor_ratio_term = motor_ratio_term;
		next_ext_ratio_term = ext_ratio_term;
		next_ratio_tolerance = ratio_tolerance;
		next_enc_cycle = enc_cycle;
		next_irq_mask = irq_mask;
		next_ext_snap = ext_snap;
		next_mot_snap = mot_snap;
		next_ext_velocity = ext_velocity;
		next_ratio_bad = ratio_bad;
		set_ev = '0;
		clr_ev = '0;

		// External position always counts, even with feedback off
		next_ext_absolute_position = ext_absolute_position;
		next_pre_count = pre_count;
		if (cnt.step) begin
			next_ext_absolute_position = step_dn ?
				ext_absolute_position - 32'h1 : ext_absolute_position + 32'h1;
			next_pre_count = step_dn ? pre_count - 32'h1 : pre_count + 32'h1;
		end
		next_motor_pos = motor_pos;
		if (motor_step) begin
			next_motor_pos = motor_down ? motor_pos - 32'h1 : motor_pos + 32'h1;
		end

		// Last seen directions
		next_ext_dn = cnt.step ? step_dn : ext_dn;
		next_ext_valid = ext_valid | cnt.step;
		next_mot_dn = motor_step ? motor_down : mot_dn;
		next_mot_valid = mot_valid | motor_step;

		// Speed window
		next_win_cnt = win_end ? 32'h0 : win_cnt + 32'h1;
		if (win_end) begin
			next_ext_velocity = ext_d[15:0];
			next_ext_snap = ext_absolute_position;
			next_mot_snap = motor_pos;
			next_ratio_bad = closed_on & (motor_ratio_term != 16'h0000) &
				(ext_ratio_term != 16'h0000) & (err_scaled > band);
		end

		// Index spacing check
		next_idx_cnt = cnt.step ? idx_cnt + 32'h1 : idx_cnt;
		next_idx_seen = idx_seen;
		if (cnt.index) begin
			if (idx_seen && enc_cycle != 32'h0 && idx_cnt != enc_cycle) begin
				set_ev[fecm_pkg::ST_INDEX] = 1'b1;
			end
			next_idx_cnt = cnt.step ? 32'h1 : 32'h0;
			next_idx_seen = 1'b1;
		end

		// Persistence filter in milliseconds
		next_ms_div = 32'h0;
		next_ms_cnt = 16'h0;
		if (bad) begin
			next_ms_div = (ms_div == 32'(MS_CYC - 1)) ? 32'h0 : ms_div + 32'h1;
			next_ms_cnt = ms_cnt;
			if (ms_div == 32'(MS_CYC - 1) && ms_cnt != 16'hffff) begin
				next_ms_cnt = ms_cnt + 16'h1;
			end
			if (ms_cnt >= mismatch_filter_time) begin
				set_ev[fecm_pkg::ST_RATIO] = ratio_bad;
				set_ev[fecm_pkg::ST_DIR] = dir_bad;
			end
		end

		// Register writes
		if (wr) begin
			if (idx == fecm_pkg::IDX_GEAR_NUM) begin
				next_gear_factor_numerator = pwdata[15:0];
			end else if (idx == fecm_pkg::IDX_PULSE_FMT) begin
				next_fmt_saved = pwdata[1:0];
			end else if (idx == fecm_pkg::IDX_PRE_CNT) begin
				next_pre_count = 32'h0;
			end else if (idx == fecm_pkg::IDX_CL_SEL) begin
				next_closed_loop_select = pwdata[7:0];
			end else if (idx == fecm_pkg::IDX_EXT_DIR) begin
				next_ext_encoder_direction = pwdata[7:0];
			end else if (idx == fecm_pkg::IDX_FILTER) begin
				next_mismatch_filter_time = pwdata[15:0];
			end else if (idx == fecm_pkg::IDX_MOT_TERM) begin
				next_motor_ratio_term = pwdata[15:0];
			end else if (idx == fecm_pkg::IDX_EXT_TERM) begin
				next_ext_ratio_term = pwdata[15:0];
			end else if (idx == fecm_pkg::IDX_TOL) begin
				next_ratio_tolerance = pwdata[7:0];
			end else if (idx == fecm_pkg::IDX_ENC_CYCLE) begin
				next_enc_cycle = pwdata;
			end else if (idx == fecm_pkg::IDX_CTRL) begin
				if (pwdata[fecm_pkg::CTRL_CLR_PRE]) begin
					next_pre_count = 32'h0;
				end
				if (pwdata[fecm_pkg::CTRL_RESTART]) begin
					next_fmt_active = fmt_saved;
				end
			end else if (idx == fecm_pkg::IDX_IRQ_STAT) begin
				clr_ev = pwdata[fecm_pkg::ST_W-1:0];
			end else if (idx == fecm_pkg::IDX_IRQ_MASK) begin
				next_irq_mask = pwdata[fecm_pkg::ST_W-1:0];
			end
		end

		// Sticky status; a new event beats a clear
		next_irq_status = (irq_status & ~clr_ev) | set_ev;

		// Read decode
		rd_ok = 1'b1;
		rd_val = 32'h0;
		if (idx == fecm_pkg::IDX_GEAR_NUM) begin
			rd_val = {16'h0, gear_factor_numerator};
		end else if (idx == fecm_pkg::IDX_PULSE_FMT) begin
			rd_val = {30'h0, fmt_saved};
		end else if (idx == fecm_pkg::IDX_PRE_CNT) begin
			rd_val = pre_count;
		end else if (idx == fecm_pkg::IDX_EXT_SPEED) begin
			rd_val = {16'h0, ext_velocity};
		end else if (idx == fecm_pkg::IDX_CL_SEL) begin
			rd_val = {24'h0, closed_loop_select};
		end else if (idx == fecm_pkg::IDX_EXT_DIR) begin
			rd_val = {24'h0, ext_encoder_direction};
		end else if (idx == fecm_pkg::IDX_FILTER) begin
			rd_val = {16'h0, mismatch_filter_time};
		end else if (idx == fecm_pkg::IDX_MOT_TERM) begin
			rd_val = {16'h0, motor_ratio_term};
		end else if (idx == fecm_pkg::IDX_EXT_TERM) begin
			rd_val = {16'h0, ext_ratio_term};
		end else if (idx == fecm_pkg::IDX_ABS_POS) begin
			rd_val = ext_absolute_position;
		end else if (idx == fecm_pkg::IDX_EXT_VEL) begin
			rd_val = {16'h0, ext_velocity};
		end else if (idx == fecm_pkg::IDX_TOL) begin
			rd_val = {24'h0, ratio_tolerance};
		end else if (idx == fecm_pkg::IDX_ENC_CYCLE) begin
			rd_val = enc_cycle;
		end else if (idx == fecm_pkg::IDX_IRQ_STAT) begin
			rd_val = {29'h0, irq_status};
		end else if (idx == fecm_pkg::IDX_IRQ_MASK) begin
			rd_val = {29'h0, irq_mask};
		end else if (idx != fecm_pkg::IDX_CTRL) begin
			rd_ok = 1'b0;
		end
		if (paddr[1:0] != 2'h0) begin
			rd_ok = 1'b0;
		end

		// One wait state, then answer
		next_pready = psel & penable & ~pready;
		next_prdata = (next_pready & ~pwrite) ? rd_val : 32'h0;
		next_pslverr = next_pready & ~rd_ok;

		next_pulse_cmd_enable = next_closed_loop_select == 8'h00;
		next_closed_loop_fault = next_irq_status[fecm_pkg::ST_RATIO] |
			next_irq_status[fecm_pkg::ST_DIR];
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gear_factor_numerator <= fecm_pkg::RST_GEAR_NUM;
			fmt_saved <= fecm_pkg::RST_PULSE_FMT;
			fmt_active <= fecm_pkg::RST_PULSE_FMT;
			closed_loop_select <= fecm_pkg::RST_CL_SEL;
			ext_encoder_direction <= fecm_pkg::RST_EXT_DIR;
			mismatch_filter_time <= fecm_pkg::RST_FILTER;
			motor_ratio_term <= fecm_pkg::RST_MOT_TERM;
			ext_ratio_term <= fecm_pkg::RST_EXT_TERM;
			ratio_tolerance <= fecm_pkg::RST_TOL;
			enc_cycle <= fecm_pkg::RST_ENC_CYCLE;
			pre_count <= 32'h0;
			ext_absolute_position <= 32'h0;
			motor_pos <= 32'h0;
			ext_snap <= 32'h0;
			mot_snap <= 32'h0;
			ext_velocity <= 16'h0;
			win_cnt <= 32'h0;
			idx_cnt <= 32'h0;
			idx_seen <= 1'b0;
			ext_dn <= 1'b0;
			ext_valid <= 1'b0;
			mot_dn <= 1'b0;
			mot_valid <= 1'b0;
			ratio_bad <= 1'b0;
			ms_div <= 32'h0;
			ms_cnt <= 16'h0;
			irq_status <= '0;
			irq_mask <= '0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			pulse_cmd_enable <= 1'b1;
			closed_loop_fault <= 1'b0;
			irq <= 1'b0;
		end else begin
			gear_factor_numerator <= next_gear_factor_numerator;
			fmt_saved <= next_fmt_saved;
			fmt_active <= next_fmt_active;
			closed_loop_select <= next_closed_loop_select;
			ext_encoder_direction <= next_ext_encoder_direction;
			mismatch_filter_time <= next_mismatch_filter_time;
			motor_ratio_term <= next_motor_ratio_term;
			ext_ratio_term <= next_ext_ratio_term;
			ratio_tolerance <= next_ratio_tolerance;
			enc_cycle <= next_enc_cycle;
			pre_count <= next_pre_count;
			ext_absolute_position <= next_ext_absolute_position;
			motor_pos <= next_motor_pos;
			ext_snap <= next_ext_snap;
			mot_snap <= next_mot_snap;
			ext_velocity <= next_ext_velocity;
			win_cnt <= next_win_cnt;
			idx_cnt <= next_idx_cnt;
			idx_seen <= next_idx_seen;
			ext_dn <= next_ext_dn;
			ext_valid <= next_ext_valid;
			mot_dn <= next_mot_dn;
			mot_valid <= next_mot_valid;
			ratio_bad <= next_ratio_bad;
			ms_div <= next_ms_div;
			ms_cnt <= next_ms_cnt;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			pulse_cmd_enable <= next_pulse_cmd_enable;
			closed_loop_fault <= next_closed_loop_fault;
			irq <= next_irq;
		end
	end
endmodule

/* fecm_top_asserts.sv */
`timescale 1ns/10ps
module fecm_top_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [23:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Status
	input wire logic pulse_cmd_enable,
	input wire logic closed_loop_fault,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic wr;
	logic sel_nz;
	logic [2:0] msk;
	assign wr = psel && penable && pready && pwrite;
	// Shadow of the select and mask registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sel_nz <= 1'b0;
			msk <= 3'h0;
		end else if (wr && paddr == {fecm_pkg::IDX_CL_SEL, 2'b00}) begin
			sel_nz <= pwdata[7:0] != 8'h00;
		end else if (wr && paddr == {fecm_pkg::IDX_IRQ_MASK, 2'b00}) begin
			msk <= pwdata[2:0];
		end
	end
	property p_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_wait: assert property (p_wait) else $error("access not answered");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	property p_cause;
		pready |-> $past(psel) && $past(penable);
	endproperty
	a_cause: assert property (p_cause) else $error("ready without access");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer");
	property p_pce;
		$stable(sel_nz) |-> pulse_cmd_enable == !sel_nz;
	endproperty
	a_pce: assert property (p_pce) else $error("pulse command enable wrong");
	property p_hold;
		closed_loop_fault && !wr && !$past(wr) |=> closed_loop_fault;
	endproperty
	a_hold: assert property (p_hold) else $error("fault dropped alone");
	property p_on;
		$rose(closed_loop_fault) |-> !pulse_cmd_enable;
	endproperty
	a_on: assert property (p_on) else $error("fault with loop off");
	property p_irq;
		irq |-> msk != 3'h0;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt while masked");
	c_err: cover property (pslverr);
	c_flt: cover property ($rose(closed_loop_fault));
	c_irq: cover property ($rose(irq));
endmodule
bind fecm_top fecm_top_chk u_fecm_top_chk (.clock, .sys_rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.pulse_cmd_enable, .closed_loop_fault, .irq);

/* fecm_enc_model.sv */
`timescale 1ns/10ps
module fecm_enc_model (
	// Clock
	input wire logic clock,
	// Motion request
	input wire logic start,
	input wire logic [15:0] steps,
	input wire logic rev,
	input wire logic [7:0] per,
	input wire logic [15:0] cyc,
	// Encoder lines and busy flag
	output logic a,
	output logic b,
	output logic z,
	output logic busy
);
	logic [15:0] left = 16'h0;
	logic [15:0] pos = 16'h1;
	logic [7:0] tick = 8'h0;
	logic [1:0] ph = 2'h0;
	always @(posedge clock) begin
		if (start) begin
			left <= steps;
		end else if (left != 16'h0) begin
			tick <= tick + 8'h1;
			// Step spacing keeps the line rate legal
			if (tick + 8'h1 >= per) begin
				tick <= 8'h0;
				left <= left - 16'h1;
				ph <= rev ? ph - 2'h1 : ph + 2'h1;
				if (rev)
					pos <= (pos == 16'h0 || pos >= cyc) ? cyc - 16'h1 : pos - 16'h1;
				else
					pos <= (pos + 16'h1 >= cyc) ? 16'h0 : pos + 16'h1;
			end
		end
	end
	// Phase A leads B when moving forward
	assign a = ph == 2'h1 || ph == 2'h2;
	assign b = ph[1];
	assign z = pos == 16'h0;
	assign busy = left != 16'h0;
endmodule

/* tb.sv */
`timescale 1ns/10ps
module tb;
	logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [23:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, bs;
	logic pready, pslverr, pa, pb, pz, pce, flt, irq, busy;
	logic mstep = 0, mdn = 0, st = 0, rev = 0, er;
	logic [15:0] nst = 0, cyc = 16;
	logic [7:0] per = 10, mper = 0, mc = 0;
	int num_errors = 0, n_tests = 0, ticks = 0;
	logic [21:0] ri [10] = '{fecm_pkg::IDX_GEAR_NUM, fecm_pkg::IDX_PULSE_FMT,
		fecm_pkg::IDX_CL_SEL, fecm_pkg::IDX_EXT_DIR, fecm_pkg::IDX_FILTER,
		fecm_pkg::IDX_MOT_TERM, fecm_pkg::IDX_EXT_TERM, fecm_pkg::IDX_TOL,
		fecm_pkg::IDX_ENC_CYCLE, fecm_pkg::IDX_IRQ_MASK};
	logic [31:0] rv [10] = '{32'h3e8, 32'h1, 32'h0, 32'h1, 32'ha, 32'h0,
		32'h0, 32'h6, 32'h0, 32'h0};
	fecm_top #(.SPEED_WIN_CYC(50), .MS_CYC(20)) u_fecm_top (.clock,
		.sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .phase_a_input_pos(pa), .phase_b_input_pos(pb),
		.index_input_pos(pz), .motor_step(mstep), .motor_down(mdn),
		.pulse_cmd_enable(pce), .closed_loop_fault(flt), .irq);
	fecm_enc_model u_fecm_enc_model (.clock, .start(st), .steps(nst), .rev,
		.per, .cyc, .a(pa), .b(pb), .z(pz), .busy);
	initial forever #5 clock = ~clock;
	// Motor increments and run limit
	always @(posedge clock) begin
		mc <= (mc + 8'h1 >= mper) ? 8'h0 : mc + 8'h1;
		mstep <= mper != 8'h0 && mc == 8'h0;
		ticks <= ticks + 1;
		if (ticks == 80000) begin
			num_errors++;
			summarize();
		end
	end
	task summarize;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [23:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock) penable <= 1'b1;
		// Only pready or the run limit ends this wait
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task wr(input logic [21:0] i, input logic [31:0] d);
		bus(1'b1, {i, 2'b00}, d);
	endtask
	task rdc(input logic [21:0] i, input logic [31:0] e);
		bus(1'b0, {i, 2'b00}, 32'h0);
		chk(rd, e);
	endtask
	task mv(input logic [15:0] n, input logic r, input logic [7:0] p);
		nst <= n;
		rev <= r;
		per <= p;
		st <= 1'b1;
		@(posedge clock) st <= 1'b0;
	endtask
	task fin;
		do begin
			@(posedge clock);
		end while (busy !== 1'b0);
		repeat (8) @(posedge clock);
	endtask
	task waitf(input int n);
		int k;
		k = 0;
		while (flt !== 1'b1 && k < n) begin
			@(posedge clock);
			k++;
		end
		chk({31'h0, flt}, 32'h1);
	endtask
	task t_regs;
		for (int i = 0; i < 10; i++)
			rdc(ri[i], rv[i]);
		chk({29'h0, pce, flt, irq}, 32'h4);
		bus(1'b0, 24'h000004, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		bus(1'b0, {fecm_pkg::IDX_GEAR_NUM, 2'b10}, 32'h0);
		chk({31'h0, er}, 32'h1);
		wr(fecm_pkg::IDX_EXT_SPEED, 32'h1234);
		rdc(fecm_pkg::IDX_EXT_SPEED, 32'h0);
	endtask
	task t_fmt;
		wr(fecm_pkg::IDX_PULSE_FMT, 32'h2);
		mv(16'h8, 1'b0, 8'ha);
		fin();
		rdc(fecm_pkg::IDX_PRE_CNT, 32'h2);
		for (int f = 0; f < 3; f++) begin
			wr(fecm_pkg::IDX_PULSE_FMT, f);
			wr(fecm_pkg::IDX_CTRL, 32'h3);
			mv(16'h8, 1'b0, 8'ha);
			fin();
			rdc(fecm_pkg::IDX_PRE_CNT, f == 2 ? 32'h8 : f == 1 ? 32'h2 : 32'h0);
		end
	endtask
	task t_cnt;
		wr(fecm_pkg::IDX_CTRL, 32'h1);
		mv(16'hc8, 1'b0, 8'ha);
		repeat (150) @(posedge clock);
		rdc(fecm_pkg::IDX_EXT_VEL, 32'h5);
		rdc(fecm_pkg::IDX_EXT_SPEED, 32'h5);
		fin();
		rdc(fecm_pkg::IDX_PRE_CNT, 32'hc8);
		wr(fecm_pkg::IDX_CTRL, 32'h1);
		rdc(fecm_pkg::IDX_PRE_CNT, 32'h0);
		wr(fecm_pkg::IDX_EXT_DIR, 32'h0);
		bus(1'b0, {fecm_pkg::IDX_ABS_POS, 2'b00}, 32'h0);
		bs = rd;
		mv(16'h8, 1'b0, 8'ha);
		fin();
		rdc(fecm_pkg::IDX_ABS_POS, bs - 32'h8);
		wr(fecm_pkg::IDX_EXT_DIR, 32'h1);
	endtask
	task t_dir;
		wr(fecm_pkg::IDX_FILTER, 32'h2);
		wr(fecm_pkg::IDX_CL_SEL, 32'h1);
		repeat (2) @(posedge clock);
		chk({31'h0, pce}, 32'h0);
		mper <= 8'ha;
		mv(16'h64, 1'b1, 8'ha);
		repeat (30) @(posedge clock);
		chk({31'h0, flt}, 32'h0);
		waitf(100);
		chk({31'h0, irq}, 32'h0);
		rdc(fecm_pkg::IDX_IRQ_STAT, 32'h2);
		wr(fecm_pkg::IDX_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		mper <= 8'h0;
		fin();
		chk({31'h0, flt}, 32'h1);
		mv(16'h4, 1'b0, 8'ha);
		fin();
		wr(fecm_pkg::IDX_IRQ_STAT, 32'h7);
		repeat (2) @(posedge clock);
		chk({30'h0, flt, irq}, 32'h0);
		wr(fecm_pkg::IDX_EXT_DIR, 32'h0);
		mper <= 8'ha;
		mv(16'h64, 1'b1, 8'ha);
		fin();
		chk({31'h0, flt}, 32'h0);
		mper <= 8'h0;
		wr(fecm_pkg::IDX_EXT_DIR, 32'h1);
		// Both moving down: no direction fault
		mdn <= 1'b1;
		mper <= 8'ha;
		mv(16'h64, 1'b1, 8'ha);
		fin();
		chk({31'h0, flt}, 32'h0);
		mper <= 8'h0;
		mdn <= 1'b0;
	endtask
	task t_ratio;
		wr(fecm_pkg::IDX_FILTER, 32'ha);
		mper <= 8'ha;
		mv(16'h258, 1'b0, 8'h19);
		repeat (100) @(posedge clock);
		wr(fecm_pkg::IDX_MOT_TERM, 32'h2);
		wr(fecm_pkg::IDX_EXT_TERM, 32'h5);
		repeat (400) @(posedge clock);
		chk({31'h0, flt}, 32'h0);
		wr(fecm_pkg::IDX_EXT_TERM, 32'h1);
		waitf(400);
		rdc(fecm_pkg::IDX_IRQ_STAT, 32'h1);
		wr(fecm_pkg::IDX_EXT_TERM, 32'h0);
		// Let a window end drop the ratio flag first
		repeat (60) @(posedge clock);
		wr(fecm_pkg::IDX_IRQ_STAT, 32'h7);
		repeat (300) @(posedge clock);
		chk({31'h0, flt}, 32'h0);
		mper <= 8'h0;
		fin();
	endtask
	task t_idx;
		wr(fecm_pkg::IDX_CL_SEL, 32'h0);
		wr(fecm_pkg::IDX_ENC_CYCLE, 32'h10);
		// Slow line rate, as on the regular port
		mv(16'h14, 1'b0, 8'h40);
		fin();
		wr(fecm_pkg::IDX_IRQ_STAT, 32'h7);
		mv(16'h40, 1'b0, 8'h40);
		fin();
		rdc(fecm_pkg::IDX_IRQ_STAT, 32'h0);
		cyc <= 16'hc;
		mv(16'h30, 1'b0, 8'h40);
		fin();
		rdc(fecm_pkg::IDX_IRQ_STAT, 32'h4);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		t_regs();
		t_fmt();
		t_cnt();
		t_dir();
		t_ratio();
		t_idx();
		summarize();
	end
endmodule
